// [pdmc_pkg.sv]
// package for the power-down mode controller
package pdmc_pkg;

    localparam int          WAIT_SEL_BIT   = 2;
    localparam logic        WAIT_SEL_RESET = 1'b0;
    localparam int          CLK_HZ         = 40000000;
    localparam int          WARMUP_US      = 100;
    localparam int          WARMUP_CYCLES  = (CLK_HZ / 1000000) * WARMUP_US;
    localparam logic [15:0] WARMUP_LOAD    = 16'(WARMUP_CYCLES);
    localparam logic [15:0] CNT_ZERO       = 16'h0000;

    typedef enum logic [2:0] {
        PDMC_RUN     = 3'b000,
        PDMC_SHALLOW = 3'b001,
        PDMC_DEEP    = 3'b010,
        PDMC_STOP    = 3'b011,
        PDMC_WARMUP  = 3'b100
    } pdmc_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic osc_en;
        logic irq_logic_en;
        logic periph_en;
        logic retain;
    } pdmc_gate_t;

    typedef struct packed {
        logic resume;
        logic take_vector;
    } pdmc_wake_t;

endpackage

// [pdmc_top.sv]
// power-down mode controller: wait, deep wait and stop states
// Overview of operation
// - sleep instruction with select bit clear enters shallow wait
// - sleep instruction with select bit set enters deep wait
// - halt instruction enters stop regardless of select bit
// - any interrupt or reset wakes from either wait mode
// - only hardware reset leaves stop; interrupts are ignored there
// - shallow wait stops CPU; oscillator, interrupts, timers, sound run
// - registers, RAM and pins hold their state while powered down
// - masked interrupt wake resumes after sleep instruction, no service
// - unmasked interrupt wake fetches vector and runs service routine
// - deep wait keeps timers and sound only on slow crystal clock
// - deep wait wake inserts warm-up; shallow wake does not
// - stop keeps timers and sound only on slow crystal clock
`timescale 1ns/100ps
module pdmc_top
    import pdmc_pkg::*;
#(
    parameter logic [15:0] WARMUP_CNT = WARMUP_LOAD
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // cpu instruction strobes
    input  wire logic        sleep_instruction_in,
    input  wire logic        halt_instruction_in,
    input  wire logic        irq_mask_in,
    // system control register image
    input  wire logic [7:0]  system_control_register_in,
    // clock source and interrupt
    input  wire logic        periph_on_xtal_in,
    input  wire logic        irq_req_in,
    // gating outputs
    output logic             cpu_clk_en_out,
    output logic             osc_en_out,
    output logic             irq_logic_en_out,
    output logic             periph_en_out,
    output logic             retain_out,
    // wake outputs
    output logic             resume_out,
    output logic             take_vector_out,
    output logic [2:0]       state_out
);

    ////////////////////////////////////////////////////////////////////////////
    // async interrupt request synchroniser
    logic [1:0] irq_sync_r;
    logic [1:0] irq_sync_nxt;

    always_comb begin
        irq_sync_nxt = {irq_sync_r[0], irq_req_in};
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_sync_r <= 2'h0;
        end else begin
            irq_sync_r <= irq_sync_nxt;
        end
    end

    logic irq_s;
    assign irq_s = irq_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // state machine
    pdmc_state_t state_r;
    pdmc_state_t state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        vec_r;
    logic        vec_nxt;
    pdmc_gate_t  gate_r;
    pdmc_gate_t  gate_nxt;
    pdmc_wake_t  wake_r;
    pdmc_wake_t  wake_nxt;

    function automatic pdmc_gate_t gates(input pdmc_state_t s, input logic xtal);
        pdmc_gate_t g;
        g = '{cpu_clk_en: 1'b1, osc_en: 1'b1, irq_logic_en: 1'b1, periph_en: 1'b1, retain: 1'b0};
        case (s)
            PDMC_RUN: begin
                g = g;
            end
            PDMC_SHALLOW: begin
                g.cpu_clk_en = 1'b0;
                g.retain     = 1'b1;
            end
            PDMC_DEEP: begin
                g.cpu_clk_en = 1'b0;
                g.osc_en     = 1'b0;
                g.periph_en  = xtal;
                g.retain     = 1'b1;
            end
            PDMC_STOP: begin
                g.cpu_clk_en   = 1'b0;
                g.osc_en       = 1'b0;
                g.irq_logic_en = 1'b0;
                g.periph_en    = xtal;
                g.retain       = 1'b1;
            end
            PDMC_WARMUP: begin
                g.cpu_clk_en = 1'b0;
                g.retain     = 1'b1;
            end
            default: begin
                g = g;
            end
        endcase
        return g;
    endfunction

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        vec_nxt   = vec_r;
        wake_nxt  = '{resume: 1'b0, take_vector: 1'b0};
        case (state_r)
            PDMC_RUN: begin
                if (halt_instruction_in) begin
                    state_nxt = PDMC_STOP;
                end else if (sleep_instruction_in) begin
                    if (system_control_register_in[WAIT_SEL_BIT]) begin
                        state_nxt = PDMC_DEEP;
                    end else begin
                        state_nxt = PDMC_SHALLOW;
                    end
                end
            end
            PDMC_SHALLOW: begin
                if (irq_s) begin
                    state_nxt            = PDMC_RUN;
                    wake_nxt.resume      = 1'b1;
                    wake_nxt.take_vector = !irq_mask_in;
                end
            end
            PDMC_DEEP: begin
                if (irq_s) begin
                    state_nxt = PDMC_WARMUP;
                    cnt_nxt   = WARMUP_CNT;
                    vec_nxt   = !irq_mask_in;
                end
            end
            PDMC_STOP: begin
                state_nxt = PDMC_STOP;
            end
            PDMC_WARMUP: begin
                if (cnt_r <= 16'h0001) begin
                    state_nxt            = PDMC_RUN;
                    cnt_nxt              = CNT_ZERO;
                    wake_nxt.resume      = 1'b1;
                    wake_nxt.take_vector = vec_r;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: begin
                state_nxt = PDMC_RUN;
            end
        endcase
        gate_nxt = gates(state_nxt, periph_on_xtal_in);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= PDMC_RUN;
            cnt_r   <= CNT_ZERO;
            vec_r   <= 1'b0;
            gate_r  <= '{cpu_clk_en: 1'b1, osc_en: 1'b1, irq_logic_en: 1'b1, periph_en: 1'b1, retain: 1'b0};
            wake_r  <= '{resume: 1'b0, take_vector: 1'b0};
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            vec_r   <= vec_nxt;
            gate_r  <= gate_nxt;
            wake_r  <= wake_nxt;
        end
    end

    assign cpu_clk_en_out   = gate_r.cpu_clk_en;
    assign osc_en_out       = gate_r.osc_en;
    assign irq_logic_en_out = gate_r.irq_logic_en;
    assign periph_en_out    = gate_r.periph_en;
    assign retain_out       = gate_r.retain;
    assign resume_out       = wake_r.resume;
    assign take_vector_out  = wake_r.take_vector;
    assign state_out        = state_r;

    ////////////////////////////////////////////////////////////////////////////
    // warm-up length monitor for the assertions
    logic [15:0] warm_len_r;
    logic [15:0] warm_len_nxt;

    always_comb begin
        if (state_r == PDMC_WARMUP) begin
            warm_len_nxt = warm_len_r + 16'h0001;
        end else begin
            warm_len_nxt = CNT_ZERO;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            warm_len_r <= CNT_ZERO;
        end else begin
            warm_len_r <= warm_len_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    a_shallow_entry: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_RUN && sleep_instruction_in && !halt_instruction_in
         && !system_control_register_in[WAIT_SEL_BIT]) |=> state_r == PDMC_SHALLOW)
        else $error("shallow wait not entered");
    a_deep_entry: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_RUN && sleep_instruction_in && !halt_instruction_in
         && system_control_register_in[WAIT_SEL_BIT]) |=> state_r == PDMC_DEEP)
        else $error("deep wait not entered");
    a_stop_entry: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_RUN && halt_instruction_in) |=> state_r == PDMC_STOP)
        else $error("stop not entered");
    a_shallow_wake: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_SHALLOW && irq_s) |=> (state_r == PDMC_RUN && resume_out))
        else $error("shallow wake missing");
    a_stop_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_STOP |=> state_r == PDMC_STOP)
        else $error("left stop without reset");
    a_shallow_gates: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_SHALLOW |-> (!cpu_clk_en_out && osc_en_out && irq_logic_en_out && periph_en_out))
        else $error("shallow gating wrong");
    a_retain_down: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r != PDMC_RUN) |-> retain_out)
        else $error("retain not held");
    a_masked_wake: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_SHALLOW && irq_s && irq_mask_in) |=> !take_vector_out)
        else $error("vector taken while masked");
    a_unmasked_wake: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_SHALLOW && irq_s && !irq_mask_in) |=> take_vector_out)
        else $error("vector not taken");
    a_deep_periph: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_DEEP && $past(state_r) == PDMC_DEEP)
        |-> periph_en_out == $past(periph_on_xtal_in))
        else $error("deep peripheral gate wrong");
    a_deep_warmup: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_DEEP && irq_s) |=> state_r == PDMC_WARMUP)
        else $error("warm-up skipped");
    a_stop_periph: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_STOP && $past(state_r) == PDMC_STOP)
        |-> (periph_en_out == $past(periph_on_xtal_in) && !cpu_clk_en_out))
        else $error("stop peripheral gate wrong");
    a_warmup_gated: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_WARMUP && cnt_r > 16'h0001) |=> (state_r == PDMC_WARMUP && !cpu_clk_en_out))
        else $error("cpu clock released early");
    a_run_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_RUN && !sleep_instruction_in && !halt_instruction_in) |=> state_r == PDMC_RUN)
        else $error("run left without instruction");
    a_run_gates: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_RUN
        |-> (cpu_clk_en_out && osc_en_out && irq_logic_en_out && periph_en_out && !retain_out))
        else $error("run gating wrong");
    a_shallow_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_SHALLOW && !irq_s) |=> state_r == PDMC_SHALLOW)
        else $error("shallow wait left without wake");
    a_deep_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_DEEP && !irq_s) |=> state_r == PDMC_DEEP)
        else $error("deep wait left without wake");
    a_deep_gates: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_DEEP |-> (!cpu_clk_en_out && !osc_en_out && irq_logic_en_out && retain_out))
        else $error("deep gating wrong");
    a_stop_gates: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_STOP
        |-> (!cpu_clk_en_out && !osc_en_out && !irq_logic_en_out && retain_out))
        else $error("stop gating wrong");
    a_stop_no_wake: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_STOP |-> (!resume_out && !take_vector_out))
        else $error("wake pulse in stop");
    a_warmup_osc: assert property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_WARMUP |-> (osc_en_out && !cpu_clk_en_out && retain_out))
        else $error("warm-up gating wrong");
    a_warmup_stays: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_WARMUP && warm_len_r < WARMUP_CNT - 16'h0001) |=> state_r == PDMC_WARMUP)
        else $error("warm-up cut short");
    a_warmup_exit: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == PDMC_WARMUP && warm_len_r == WARMUP_CNT - 16'h0001)
        |=> (state_r == PDMC_RUN && cpu_clk_en_out && resume_out))
        else $error("warm-up did not end");
    a_resume_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
        resume_out |=> !resume_out)
        else $error("resume longer than one cycle");
    a_vector_pairs: assert property (@(posedge clk_in) disable iff (!rstn_in)
        take_vector_out |-> resume_out)
        else $error("vector without resume");

    c_shallow: cover property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_SHALLOW ##1 state_r == PDMC_RUN);
    c_deep: cover property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_WARMUP ##1 state_r == PDMC_RUN);
    c_stop: cover property (@(posedge clk_in) disable iff (!rstn_in)
        state_r == PDMC_STOP && irq_s);
    c_vector: cover property (@(posedge clk_in) disable iff (!rstn_in) take_vector_out);
    c_masked: cover property (@(posedge clk_in) disable iff (!rstn_in) resume_out && !take_vector_out);

endmodule // pdmc_top

// [tb_pdmc.sv]
// testbench for the power-down mode controller
`timescale 1ns/100ps
module tb_pdmc;
    import pdmc_pkg::*;

    localparam logic [15:0] WCNT = 16'h0004;

    logic        clk_in                     = 1'b0;
    logic        rstn_in                    = 1'b0;
    logic        sleep_instruction_in       = 1'b0;
    logic        halt_instruction_in        = 1'b0;
    logic        irq_mask_in                = 1'b0;
    logic [7:0]  system_control_register_in = 8'h00;
    logic        periph_on_xtal_in          = 1'b0;
    logic        irq_req_in                 = 1'b0;
    logic        cpu_clk_en_out;
    logic        osc_en_out;
    logic        irq_logic_en_out;
    logic        periph_en_out;
    logic        retain_out;
    logic        resume_out;
    logic        take_vector_out;
    logic [2:0]  state_out;
    int          n_errors                   = 0;
    int          checks                     = 0;

    always #12.5 clk_in = ~clk_in;

    pdmc_top #(.WARMUP_CNT(WCNT)) i_dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .sleep_instruction_in(sleep_instruction_in),
        .halt_instruction_in(halt_instruction_in), .irq_mask_in(irq_mask_in),
        .system_control_register_in(system_control_register_in), .periph_on_xtal_in(periph_on_xtal_in),
        .irq_req_in(irq_req_in), .cpu_clk_en_out(cpu_clk_en_out), .osc_en_out(osc_en_out),
        .irq_logic_en_out(irq_logic_en_out), .periph_en_out(periph_en_out), .retain_out(retain_out),
        .resume_out(resume_out), .take_vector_out(take_vector_out), .state_out(state_out)
    ); // pdmc_top

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask

    task automatic do_reset();
        rstn_in = 1'b0;
        tick(2);
        rstn_in = 1'b1;
        tick(1);
    endtask

    task automatic enter(input logic slp, input logic hlt, input logic sel);
        system_control_register_in               = 8'(sel) << WAIT_SEL_BIT;
        sleep_instruction_in                     = slp;
        halt_instruction_in                      = hlt;
        tick(1);
        sleep_instruction_in                     = 1'b0;
        halt_instruction_in                      = 1'b0;
    endtask

    task automatic wake(input logic mask, output int n, output int w);
        irq_mask_in = mask;
        irq_req_in  = 1'b1;
        n = 0;
        w = 0;
        do begin
            tick(1);
            n++;
            if (state_out === PDMC_WARMUP) begin
                w++;
                chk("warm_cpu", cpu_clk_en_out, 1'b0);
                chk("warm_osc", osc_en_out, 1'b1);
            end
        end while (resume_out !== 1'b1 && n < 40);
        chk("resume", resume_out, 1'b1);
        chk("vector", take_vector_out, !mask);
        chk("run_state", state_out, PDMC_RUN);
        chk("run_cpu", cpu_clk_en_out, 1'b1);
        chk("run_retain", retain_out, 1'b0);
        irq_req_in = 1'b0;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("rst_state", state_out, PDMC_RUN);
        chk("rst_gates", {cpu_clk_en_out, osc_en_out, irq_logic_en_out, periph_en_out}, 4'hF);
        chk("rst_flags", {retain_out, resume_out, take_vector_out}, 3'h0);
    endtask

    task automatic t_shallow(input logic mask);
        int n;
        int w;
        enter(1'b1, 1'b0, 1'b0);
        chk("sh_state", state_out, PDMC_SHALLOW);
        chk("sh_cpu", cpu_clk_en_out, 1'b0);
        chk("sh_run", {osc_en_out, irq_logic_en_out, periph_en_out}, 3'h7);
        chk("sh_retain", retain_out, 1'b1);
        tick(1);
        enter(1'b0, 1'b1, 1'b0);
        chk("sh_ignore", state_out, PDMC_SHALLOW);
        wake(mask, n, w);
        chk("sh_fast", (n <= 3 && w == 0), 1'b1);
    endtask

    task automatic t_deep(input logic xtal, input logic mask);
        int n;
        int w;
        periph_on_xtal_in = xtal;
        enter(1'b1, 1'b0, 1'b1);
        chk("dp_state", state_out, PDMC_DEEP);
        chk("dp_gates", {cpu_clk_en_out, osc_en_out, periph_en_out}, {2'b00, xtal});
        chk("dp_retain", retain_out, 1'b1);
        wake(mask, n, w);
        chk("dp_warm", 16'(w), WCNT);
    endtask

    task automatic t_reset_wake();
        enter(1'b1, 1'b0, 1'b1);
        do_reset();
        chk("rw_state", state_out, PDMC_RUN);
        chk("rw_cpu", cpu_clk_en_out, 1'b1);
    endtask

    task automatic t_stop(input logic xtal);
        periph_on_xtal_in = xtal;
        enter(1'b1, 1'b1, 1'b0);
        chk("st_state", state_out, PDMC_STOP);
        chk("st_gates", {cpu_clk_en_out, irq_logic_en_out, periph_en_out}, {2'b00, xtal});
        chk("st_retain", retain_out, 1'b1);
        irq_mask_in = 1'b0;
        irq_req_in  = 1'b1;
        repeat (12) begin
            tick(1);
            chk("st_hold", {resume_out, state_out}, {1'b0, PDMC_STOP});
        end
        irq_req_in = 1'b0;
        do_reset();
        chk("st_exit", state_out, PDMC_RUN);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(25 * 3000);
        n_errors++;
        test_done();
    end

    initial begin
        tick(20);
        rstn_in = 1'b1;
        tick(1);
        t_reset();
        t_shallow(1'b1);
        t_shallow(1'b0);
        t_deep(1'b1, 1'b0);
        t_deep(1'b0, 1'b1);
        t_reset_wake();
        t_stop(1'b1);
        t_stop(1'b0);
        test_done();
    end
endmodule // tb_pdmc
